// ---- hw/fcsm_regs.svh ----
// Command codes, unlock addresses and timing counts of the flash host
`ifndef FCSM_REGS_SVH
`define FCSM_REGS_SVH

// Command data bytes
`define FCSM_CD_RESET 8'hF0
`define FCSM_CD_UNLOCK1 8'hAA
`define FCSM_CD_UNLOCK2 8'h55
`define FCSM_CD_AUTOSEL 8'h90
`define FCSM_CD_SEC_ENTER 8'h88
`define FCSM_CD_ERASE_SETUP 8'h80
`define FCSM_CD_PROGRAM 8'hA0
`define FCSM_CD_SEC_EXIT 8'h00
`define FCSM_CD_CHIP_ERASE 8'h10
`define FCSM_CD_SECTOR_ERASE 8'h30
`define FCSM_CD_QUERY 8'h98

// Unlock and command addresses, word and byte mode
`define FCSM_A_CMD_WORD 12'h555
`define FCSM_A_CMD_BYTE 12'hAAA
`define FCSM_A_UNL2_WORD 12'h2AA
`define FCSM_A_UNL2_BYTE 12'h555
`define FCSM_A_QUERY_WORD 12'h055
`define FCSM_A_QUERY_BYTE 12'h0AA

// Fail flag position in the status word
`define FCSM_FAIL_BIT 5

// Timing: figures in ns, counts in 10 ns cycles
`define FCSM_CLK_NS 10
`define FCSM_GLITCH_NS 5
`define FCSM_WE_LOW_NS 35
`define FCSM_WE_LOW_CYC ((`FCSM_WE_LOW_NS + `FCSM_CLK_NS - 1) / `FCSM_CLK_NS)
`define FCSM_ACCESS_NS 90
`define FCSM_ACCESS_CYC ((`FCSM_ACCESS_NS + `FCSM_CLK_NS - 1) / `FCSM_CLK_NS)
`define FCSM_RP_NS 500
`define FCSM_RP_CYC ((`FCSM_RP_NS + `FCSM_CLK_NS - 1) / `FCSM_CLK_NS)
`define FCSM_READY_NS 20000
`define FCSM_READY_CYC ((`FCSM_READY_NS + `FCSM_CLK_NS - 1) / `FCSM_CLK_NS)

`endif

// ---- hw/fcsm_pkg.sv ----
// Types shared by the flash command host modules
`default_nettype none
package fcsm_pkg;
  // Operations the user may request
  typedef enum logic [3:0] {
    FCSM_OP_READ = 4'h0,
    FCSM_OP_RESET = 4'h1,
    FCSM_OP_PROGRAM = 4'h2,
    FCSM_OP_CHIP_ERASE = 4'h3,
    FCSM_OP_SECTOR_ERASE = 4'h4,
    FCSM_OP_AUTOSEL = 4'h5,
    FCSM_OP_SEC_ENTER = 4'h6,
    FCSM_OP_SEC_EXIT = 4'h7,
    FCSM_OP_QUERY = 4'h8,
    FCSM_OP_HW_RESET = 4'h9
  } fcsm_op_type;
endpackage : fcsm_pkg
`default_nettype wire

// ---- hw/fcsm_cyc_if.sv ----
// Request and answer path between sequencer and bus cycle engine
`default_nettype none
interface fcsm_cyc_if #(parameter int AW = 23, parameter int DW = 16);
  logic req;
  logic is_read;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic done;
  logic [DW-1:0] rdata;
  modport master (output req, output is_read, output addr, output wdata,
                  input done, input rdata);
  modport slave (input req, input is_read, input addr, input wdata,
                 output done, output rdata);
endinterface : fcsm_cyc_if
`default_nettype wire

// ---- hw/fcsm_bus_cycle.sv ----
// One timed flash bus write or read cycle on the strobe pins
`include "fcsm_regs.svh"
`default_nettype none
module fcsm_bus_cycle #(
  parameter int AW = 23,
  parameter int DW = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request side
  fcsm_cyc_if.slave cyc,
  // Flash pins
  output logic [AW-1:0] fl_addr,
  input wire logic [DW-1:0] fl_dq_in,
  output logic [DW-1:0] fl_dq_out,
  output logic fl_dq_oe,
  output logic chip_select_n,
  output logic fl_we_n,
  output logic fl_oe_n
);
  typedef enum logic [3:0] {
    CY_IDLE = 4'b0001,
    CY_SETUP = 4'b0010,
    CY_PULSE = 4'b0100,
    CY_HOLD = 4'b1000
  } fcsm_cy_type;

  localparam int PW = `FCSM_WE_LOW_CYC;
  localparam int RW = `FCSM_ACCESS_CYC;
  localparam int CNT_W = 4;

  fcsm_cy_type st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic rd_q, rd_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [DW-1:0] wd_q, wd_d;
  logic [DW-1:0] rdata_q, rdata_d;

  // Next state: chip select falls first, strobe last
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    rd_d = rd_q;
    addr_d = addr_q;
    wd_d = wd_q;
    rdata_d = rdata_q;
    cyc.done = 1'b0;
    unique case (st_q)
      CY_IDLE: begin
        if (cyc.req) begin
          rd_d = cyc.is_read;
          addr_d = cyc.addr;
          wd_d = cyc.wdata;
          st_d = CY_SETUP;
        end
      end
      CY_SETUP: begin
        // Strobe held low well past the glitch width
        cnt_d = rd_q ? CNT_W'(RW - 1) : CNT_W'(PW - 1);
        st_d = CY_PULSE;
      end
      CY_PULSE: begin
        if (cnt_q == '0) begin
          if (rd_q) rdata_d = fl_dq_in;
          st_d = CY_HOLD;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      CY_HOLD: begin
        cyc.done = 1'b1;
        st_d = CY_IDLE;
      end
    endcase
  end

  // Cycle registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= CY_IDLE;
      cnt_q <= '0;
      rd_q <= 1'b0;
      addr_q <= '0;
      wd_q <= '0;
      rdata_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      rd_q <= rd_d;
      addr_q <= addr_d;
      wd_q <= wd_d;
      rdata_q <= rdata_d;
    end
  end

  // Pins: write needs select and write strobe low, output strobe high
  assign fl_addr = addr_q;
  assign fl_dq_out = wd_q;
  assign fl_dq_oe = !rd_q && (st_q != CY_IDLE);
  assign chip_select_n = (st_q == CY_IDLE);
  assign fl_we_n = !(!rd_q && st_q == CY_PULSE);
  assign fl_oe_n = !(rd_q && st_q == CY_PULSE);
  assign cyc.rdata = rdata_q;
endmodule : fcsm_bus_cycle
`default_nettype wire

// ---- hw/fcsm_host.sv ----
// Flash command host: issues unlock and command sequences on the pins
`include "fcsm_regs.svh"
`default_nettype none
module fcsm_host #(
  parameter int AW = 23,
  parameter int DW = 16,
  parameter int RP_CYC = `FCSM_RP_CYC,
  parameter int READY_CYC = `FCSM_READY_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // User command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire fcsm_pkg::fcsm_op_type cmd_op,
  input wire logic [AW-1:0] cmd_addr,
  input wire logic [DW-1:0] cmd_data,
  input wire logic byte_mode,
  // User answer port
  output logic rsp_valid,
  output logic [DW-1:0] rsp_data,
  output logic rsp_fail,
  output logic rsp_refused,
  // Security region state
  input wire logic sec_lock_mark,
  output logic sec_mode,
  output logic sec_locked,
  // Supply monitor
  input wire logic vcc_ok,
  // Flash pins
  output logic [AW-1:0] fl_addr,
  input wire logic [DW-1:0] fl_dq_in,
  output logic [DW-1:0] fl_dq_out,
  output logic fl_dq_oe,
  output logic chip_select_n,
  output logic fl_we_n,
  output logic fl_oe_n,
  output logic fl_reset_n,
  input wire logic ready_busy_n
);
  import fcsm_pkg::*;

  typedef enum logic [7:0] {
    ST_PWR = 8'h01,
    ST_WAIT = 8'h02,
    ST_IDLE = 8'h04,
    ST_SEQ = 8'h08,
    ST_READ = 8'h10,
    ST_POLL = 8'h20,
    ST_RST = 8'h40,
    ST_RSP = 8'h80
  } fcsm_st_type;

  localparam int TW = 16;

  fcsm_cyc_if #(.AW(AW), .DW(DW)) cyc ();

  fcsm_st_type st_q, st_d;
  fcsm_op_type op_q, op_d;
  logic [AW-1:0] ua_q, ua_d;
  logic [DW-1:0] ud_q, ud_d;
  logic bm_q, bm_d;
  logic [2:0] step_q, step_d;
  logic [TW-1:0] tmr_q, tmr_d;
  logic busy_q, busy_d;
  logic need_rst_q, need_rst_d;
  logic then_read_q, then_read_d;
  logic sec_mode_q, sec_mode_d;
  logic sec_lock_q, sec_lock_d;
  logic [DW-1:0] rsp_data_q, rsp_data_d;
  logic fail_q, fail_d;
  logic refused_q, refused_d;
  logic hw_rst_q, hw_rst_d;
  logic [AW-1:0] seq_addr;
  logic [DW-1:0] seq_data;
  logic [2:0] seq_len;

  // Widen a 12-bit command address to the bus width
  function automatic logic [AW-1:0] wa(input logic [11:0] a);
    wa = {{(AW-12){1'b0}}, a};
  endfunction : wa

  // Number of writes in each sequence
  always_comb begin
    unique case (op_q)
      FCSM_OP_RESET, FCSM_OP_QUERY: seq_len = 3'd1;
      FCSM_OP_AUTOSEL, FCSM_OP_SEC_ENTER: seq_len = 3'd3;
      FCSM_OP_PROGRAM, FCSM_OP_SEC_EXIT: seq_len = 3'd4;
      FCSM_OP_CHIP_ERASE, FCSM_OP_SECTOR_ERASE: seq_len = 3'd6;
      default: seq_len = 3'd1;
    endcase
  end

  // Address and data of each write in the current sequence
  always_comb begin
    logic [AW-1:0] a_cmd;
    logic [AW-1:0] a_unl2;
    a_cmd = wa(bm_q ? `FCSM_A_CMD_BYTE : `FCSM_A_CMD_WORD);
    a_unl2 = wa(bm_q ? `FCSM_A_UNL2_BYTE : `FCSM_A_UNL2_WORD);
    seq_addr = a_cmd;
    seq_data = {8'h00, `FCSM_CD_UNLOCK1};
    if (op_q == FCSM_OP_RESET) begin
      seq_addr = ua_q;
      seq_data = {8'h00, `FCSM_CD_RESET};
    end else if (op_q == FCSM_OP_QUERY) begin
      seq_addr = wa(bm_q ? `FCSM_A_QUERY_BYTE : `FCSM_A_QUERY_WORD);
      seq_data = {8'h00, `FCSM_CD_QUERY};
    end else if (step_q == 3'd1 || step_q == 3'd4) begin
      seq_addr = a_unl2;
      seq_data = {8'h00, `FCSM_CD_UNLOCK2};
    end else if (step_q == 3'd2) begin
      unique case (op_q)
        FCSM_OP_AUTOSEL, FCSM_OP_SEC_EXIT:
          seq_data = {8'h00, `FCSM_CD_AUTOSEL};
        FCSM_OP_SEC_ENTER: seq_data = {8'h00, `FCSM_CD_SEC_ENTER};
        FCSM_OP_PROGRAM: seq_data = {8'h00, `FCSM_CD_PROGRAM};
        default: seq_data = {8'h00, `FCSM_CD_ERASE_SETUP};
      endcase
    end else if (step_q == 3'd3) begin
      if (op_q == FCSM_OP_PROGRAM) begin
        seq_addr = ua_q;
        seq_data = ud_q;
      end else if (op_q == FCSM_OP_SEC_EXIT) begin
        seq_addr = ua_q;
        seq_data = {8'h00, `FCSM_CD_SEC_EXIT};
      end
    end else if (step_q == 3'd5) begin
      if (op_q == FCSM_OP_SECTOR_ERASE) begin
        seq_addr = ua_q;
        seq_data = {8'h00, `FCSM_CD_SECTOR_ERASE};
      end else begin
        seq_data = {8'h00, `FCSM_CD_CHIP_ERASE};
      end
    end
  end

  // Sequencer next state
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    ua_d = ua_q;
    ud_d = ud_q;
    bm_d = bm_q;
    step_d = step_q;
    tmr_d = tmr_q;
    busy_d = busy_q;
    need_rst_d = need_rst_q;
    then_read_d = then_read_q;
    sec_mode_d = sec_mode_q;
    sec_lock_d = sec_lock_q | (sec_lock_mark & sec_mode_q);
    rsp_data_d = rsp_data_q;
    fail_d = fail_q;
    refused_d = refused_q;
    hw_rst_d = 1'b0;
    cmd_ready = 1'b0;
    cyc.req = 1'b0;
    cyc.is_read = 1'b0;
    cyc.addr = seq_addr;
    cyc.wdata = seq_data;
    unique case (st_q)
      ST_PWR: begin
        // Hold the reset pin low, start no strobe cycle; one begun before supply loss still completes
        hw_rst_d = 1'b1;
        if (tmr_q == '0) begin
          tmr_d = TW'(READY_CYC);
          st_d = ST_WAIT;
        end else begin
          tmr_d = tmr_q - 1'b1;
        end
      end
      ST_WAIT: begin
        // Device comes up in read array mode
        sec_mode_d = 1'b0;
        need_rst_d = 1'b0;
        if (tmr_q == '0) st_d = ST_IDLE;
        else tmr_d = tmr_q - 1'b1;
      end
      ST_IDLE: begin
        cmd_ready = vcc_ok;
        if (cmd_valid && vcc_ok) begin
          op_d = cmd_op;
          ua_d = cmd_addr;
          ud_d = cmd_data;
          bm_d = byte_mode;
          step_d = 3'd0;
          fail_d = 1'b0;
          refused_d = 1'b0;
          rsp_data_d = '0;
          if (cmd_op == FCSM_OP_HW_RESET) begin
            tmr_d = TW'(RP_CYC - 1);
            st_d = ST_PWR;
          end else if ((cmd_op == FCSM_OP_PROGRAM ||
                        cmd_op == FCSM_OP_CHIP_ERASE ||
                        cmd_op == FCSM_OP_SECTOR_ERASE) &&
                       sec_mode_q && sec_lock_q) begin
            refused_d = 1'b1;
            st_d = ST_RSP;
          end else if (cmd_op == FCSM_OP_READ) begin
            then_read_d = 1'b1;
            st_d = need_rst_q ? ST_RST : ST_READ;
          end else begin
            st_d = ST_SEQ;
          end
        end
      end
      ST_SEQ: begin
        // Full sequence written back to back, cut short only by supply loss
        cyc.req = 1'b1;
        if (cyc.done) begin
          if (step_q == seq_len - 3'd1) begin
            unique case (op_q)
              FCSM_OP_PROGRAM, FCSM_OP_CHIP_ERASE, FCSM_OP_SECTOR_ERASE: begin
                busy_d = 1'b1;
                st_d = ST_POLL;
              end
              FCSM_OP_AUTOSEL: begin
                need_rst_d = 1'b1;
                st_d = ST_READ;
              end
              FCSM_OP_QUERY: begin
                need_rst_d = 1'b1;
                st_d = ST_RSP;
              end
              FCSM_OP_SEC_ENTER: begin
                sec_mode_d = 1'b1;
                st_d = ST_RSP;
              end
              FCSM_OP_SEC_EXIT: begin
                sec_mode_d = 1'b0;
                need_rst_d = 1'b0;
                st_d = ST_RSP;
              end
              default: begin
                need_rst_d = 1'b0;
                st_d = ST_RSP;
              end
            endcase
          end else begin
            step_d = step_q + 3'd1;
          end
        end
      end
      ST_READ: begin
        // Plain array or identification read at the user address
        cyc.req = 1'b1;
        cyc.is_read = 1'b1;
        cyc.addr = ua_q;
        if (cyc.done) begin
          rsp_data_d = cyc.rdata;
          then_read_d = 1'b0;
          st_d = ST_RSP;
        end
      end
      ST_POLL: begin
        // Status read; no reset while running and not failed
        cyc.req = 1'b1;
        cyc.is_read = 1'b1;
        cyc.addr = ua_q;
        if (cyc.done) begin
          rsp_data_d = cyc.rdata;
          if (ready_busy_n) begin
            busy_d = 1'b0;
            st_d = ST_RSP;
          end else if (cyc.rdata[`FCSM_FAIL_BIT]) begin
            fail_d = 1'b1;
            busy_d = 1'b0;
            need_rst_d = 1'b1;
            then_read_d = 1'b0;
            st_d = ST_RST;
          end
        end
      end
      ST_RST: begin
        // Reset write clears fail or special mode
        cyc.req = 1'b1;
        cyc.addr = ua_q;
        cyc.wdata = {8'h00, `FCSM_CD_RESET};
        if (cyc.done) begin
          need_rst_d = 1'b0;
          st_d = then_read_q ? ST_READ : ST_RSP;
        end
      end
      ST_RSP: begin
        st_d = ST_IDLE;
      end
    endcase
    // Supply loss: device resets itself, host restarts from scratch
    if (!vcc_ok && st_q != ST_PWR && st_q != ST_WAIT) begin
      busy_d = 1'b0;
      tmr_d = TW'(RP_CYC - 1);
      st_d = ST_PWR;
    end
  end

  // Sequencer registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_PWR;
      op_q <= FCSM_OP_READ;
      ua_q <= '0;
      ud_q <= '0;
      bm_q <= 1'b0;
      step_q <= 3'd0;
      tmr_q <= TW'(RP_CYC - 1);
      busy_q <= 1'b0;
      need_rst_q <= 1'b0;
      then_read_q <= 1'b0;
      sec_mode_q <= 1'b0;
      sec_lock_q <= 1'b0;
      rsp_data_q <= '0;
      fail_q <= 1'b0;
      refused_q <= 1'b0;
      hw_rst_q <= 1'b1;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      ua_q <= ua_d;
      ud_q <= ud_d;
      bm_q <= bm_d;
      step_q <= step_d;
      tmr_q <= tmr_d;
      busy_q <= busy_d;
      need_rst_q <= need_rst_d;
      then_read_q <= then_read_d;
      sec_mode_q <= sec_mode_d;
      sec_lock_q <= sec_lock_d;
      rsp_data_q <= rsp_data_d;
      fail_q <= fail_d;
      refused_q <= refused_d;
      hw_rst_q <= hw_rst_d;
    end
  end

  // Timed pin cycles
  fcsm_bus_cycle #(.AW(AW), .DW(DW)) u_cycle (
    .clk(clk),
    .rst_n(rst_n),
    .cyc(cyc.slave),
    .fl_addr(fl_addr),
    .fl_dq_in(fl_dq_in),
    .fl_dq_out(fl_dq_out),
    .fl_dq_oe(fl_dq_oe),
    .chip_select_n(chip_select_n),
    .fl_we_n(fl_we_n),
    .fl_oe_n(fl_oe_n)
  );

  // Answer and status outputs
  assign rsp_valid = (st_q == ST_RSP);
  assign rsp_data = rsp_data_q;
  assign rsp_fail = fail_q;
  assign rsp_refused = refused_q;
  assign sec_mode = sec_mode_q;
  assign sec_locked = sec_lock_q;
  assign fl_reset_n = !hw_rst_q;
endmodule : fcsm_host
`default_nettype wire

// ---- sim/fcsm_host_asserts.sv ----
// Concurrent checks on the ports of the flash command host
`default_nettype none
module fcsm_host_asserts #(
  parameter int AW = 23,
  parameter int DW = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // User side
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire fcsm_pkg::fcsm_op_type cmd_op,
  input wire logic [AW-1:0] cmd_addr,
  input wire logic [DW-1:0] cmd_data,
  input wire logic byte_mode,
  input wire logic rsp_valid,
  input wire logic [DW-1:0] rsp_data,
  input wire logic rsp_fail,
  input wire logic rsp_refused,
  input wire logic sec_lock_mark,
  input wire logic sec_mode,
  input wire logic sec_locked,
  input wire logic vcc_ok,
  // Flash pins
  input wire logic [AW-1:0] fl_addr,
  input wire logic [DW-1:0] fl_dq_in,
  input wire logic [DW-1:0] fl_dq_out,
  input wire logic fl_dq_oe,
  input wire logic chip_select_n,
  input wire logic fl_we_n,
  input wire logic fl_oe_n,
  input wire logic fl_reset_n,
  input wire logic ready_busy_n
);
  import fcsm_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Write strobe low for four cycles, then released
  sequence we_low_s;
    (!fl_we_n)[*4] ##1 fl_we_n;
  endsequence
  // Select still low at strobe release, high one cycle later
  sequence cs_rise_s;
    !chip_select_n ##1 chip_select_n;
  endsequence
  // Program or erase taken while the locked region is open
  sequence locked_take_s;
    cmd_valid && cmd_ready && sec_mode && sec_locked && (cmd_op inside
      {FCSM_OP_PROGRAM, FCSM_OP_CHIP_ERASE, FCSM_OP_SECTOR_ERASE});
  endsequence
  write_qual_a: assert property (
    !fl_we_n |-> !chip_select_n && fl_oe_n && fl_dq_oe)
    else $error("write strobe outside a qualified cycle");
  read_qual_a: assert property (
    !fl_oe_n |-> fl_we_n && !fl_dq_oe)
    else $error("read strobe overlaps a write");
  pulse_width_a: assert property (
    $fell(fl_we_n) |-> we_low_s)
    else $error("write pulse length wrong");
  data_latch_a: assert property (
    $rose(fl_we_n) |-> cs_rise_s)
    else $error("select not held past strobe release");
  addr_hold_a: assert property (
    !fl_we_n && !$past(fl_we_n) |-> $stable(fl_addr) && $stable(fl_dq_out))
    else $error("address or data moved under the strobe");
  supply_block_a: assert property (
    !vcc_ok |-> !cmd_ready)
    else $error("command taken on low supply");
  pin_reset_a: assert property (
    !fl_reset_n |-> chip_select_n && fl_we_n && fl_oe_n)
    else $error("strobes active during pin reset");
  lock_refuse_a: assert property (
    locked_take_s |-> chip_select_n ##1 (chip_select_n && rsp_valid && rsp_refused))
    else $error("locked region not refused");
  lock_sticky_a: assert property (
    sec_locked |=> sec_locked)
    else $error("region lock cleared");
endmodule : fcsm_host_asserts

bind fcsm_host fcsm_host_asserts #(.AW(AW), .DW(DW)) u_asserts (
  .clk, .rst_n, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_data,
  .byte_mode, .rsp_valid, .rsp_data, .rsp_fail, .rsp_refused, .sec_lock_mark,
  .sec_mode, .sec_locked, .vcc_ok, .fl_addr, .fl_dq_in, .fl_dq_out, .fl_dq_oe,
  .chip_select_n, .fl_we_n, .fl_oe_n, .fl_reset_n, .ready_busy_n);
`default_nettype wire

// ---- sim/fcsm_flash_model.sv ----
// Behavioural model of the flash device behind the host pins
`default_nettype none
module fcsm_flash_model #(
  parameter logic [15:0] MAKER = 16'h005A, // Arbitrary value
  parameter logic [15:0] QUERY_WORD = 16'h0A5C // Arbitrary value
) (
  // Host pins
  input wire logic [22:0] fl_addr,
  input wire logic [15:0] dq_bus,
  input wire logic chip_select_n,
  input wire logic fl_we_n,
  input wire logic fl_oe_n,
  input wire logic fl_reset_n,
  // Board level
  input wire logic byte_mode,
  input wire logic vcc_ok,
  input wire logic sec_lock_mark,
  // Device outputs
  output logic [15:0] dq_drv,
  output logic ready_busy_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [logic [22:0]];
  logic [15:0] rd, hold;
  logic [22:0] a_lat;
  logic [7:0] kind = 8'h00;
  logic sec = '0, locked = '0, busy = '0, failed = '0, fail_next = '0;
  logic id_mode = '0, query = '0, skip1 = '0;
  int step = 0, n_ops = 0, busy_ns = 300;
  realtime t_fall = 0;

  function automatic logic [15:0] rdm(input logic [22:0] a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction : rdm

  // Embedded operation: busy, then done or stuck failed
  task automatic start();
    n_ops++;
    busy = 1'h1;
    if (fail_next) failed = 1'h1;
    else fork #(busy_ns) busy = 1'h0; join_none
    fail_next = 1'h0;
  endtask : start

  // Command decoder; any misfit clears the step and identification mode, not query mode
  task automatic do_write(input logic [22:0] a, input logic [15:0] d);
    logic [7:0] c;
    logic [11:0] lo, c1, c2;
    c = d[7:0];
    lo = a[11:0];
    c1 = byte_mode ? 12'hAAA : 12'h555;
    c2 = byte_mode ? 12'h555 : 12'h2AA;
    if (busy && !failed) return;
    if (step == 3 && kind == 8'hA0) begin
      if (!(sec && locked)) mem[a] = rdm(a) & d;
      if (!(sec && locked)) start();
      step = 0;
    end else if (c == 8'hF0) begin
      step = 0;
      {id_mode, query, failed, busy} = 4'h0;
    end else if (step == 0 && lo == (byte_mode ? 12'h0AA : 12'h055)
                 && c == 8'h98) query = 1'h1;
    else if (step == 0 && lo == c1 && c == 8'hAA) step = 1;
    else if (step == 1 && lo == c2 && c == 8'h55) step = 2;
    else if (step == 2 && lo == c1 && c inside {8'h90, 8'h88, 8'hA0, 8'h80})
    begin
      kind = c;
      step = (c == 8'h88) ? 0 : 3;
      sec = sec | (c == 8'h88);
      id_mode = (c == 8'h90);
    end else if (step == 3 && kind == 8'h90 && c == 8'h00) begin
      {sec, id_mode} = 2'h0;
      step = 0;
    end else if (step == 3 && kind == 8'h80 && lo == c1 && c == 8'hAA) step = 4;
    else if (step == 4 && lo == c2 && c == 8'h55) step = 5;
    else if (step == 5 && (c == 8'h30 || (c == 8'h10 && lo == c1))) begin
      if (!(sec && locked)) mem.delete();
      if (!(sec && locked)) start();
      step = 0;
    end else begin
      step = 0;
      id_mode = 1'h0;
    end
  endtask : do_write

  // Power-up in read array; a write held through power-up is dropped
  initial #1 skip1 = (!fl_we_n && !chip_select_n && fl_oe_n) === 1'h1;
  // Address on the later falling strobe
  always @(negedge fl_we_n) begin
    t_fall = $realtime;
    a_lat = fl_addr;
  end
  // Data on the first rising strobe of a qualified, long enough cycle
  always @(posedge fl_we_n) begin
    if (!chip_select_n && fl_oe_n && vcc_ok && fl_reset_n
        && $realtime - t_fall >= 5.0) begin
      if (skip1) skip1 = 1'h0;
      else do_write(a_lat, dq_bus);
    end
  end
  // Pin reset or supply loss returns to read array
  always @(negedge fl_reset_n or negedge vcc_ok) begin
    step = 0;
    {id_mode, query, sec, busy, failed} = 5'h00;
  end
  // Lock only while the region is entered; never undone
  always @(posedge sec_lock_mark) if (sec) locked = 1'h1;
  // Read data by mode
  always @* begin
    if (busy) rd = {10'h000, failed, 5'h00};
    else if (id_mode) begin
      case (byte_mode ? fl_addr[8:1] : fl_addr[7:0])
        8'h00: rd = MAKER;
        8'h03: rd = {15'h0000, locked};
        default: rd = 16'h0000;
      endcase
    end else if (query) rd = QUERY_WORD;
    else rd = rdm(fl_addr);
  end
  // Released data lines show the inverse of the last value
  always @* if (!chip_select_n && !fl_oe_n) hold = rd;
  assign dq_drv = (!chip_select_n && !fl_oe_n) ? rd : ~hold;
  assign ready_busy_n = !busy; // Pulled up when idle
endmodule : fcsm_flash_model
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the flash command host and device model
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import fcsm_pkg::*;
  logic clk = 1'h0, rst_n = 1'h0, cmd_valid = 1'h0, byte_mode = 1'h0;
  logic sec_lock_mark = 1'h0, vcc_ok = 1'h1;
  fcsm_op_type cmd_op = FCSM_OP_READ;
  logic [22:0] cmd_addr = 23'h000000, fl_addr;
  logic [15:0] cmd_data = 16'h0000, fl_dq_out, fm_dq, dq_bus, rsp_data;
  logic cmd_ready, rsp_valid, rsp_fail, rsp_refused, sec_mode, sec_locked;
  logic fl_dq_oe, chip_select_n, fl_we_n, fl_oe_n, fl_reset_n, ready_busy_n;
  int err_total = 0, total_checks = 0;
  logic [31:0] rnd = 32'h00000024;
  logic [15:0] shadow [logic [22:0]];
  // Shared data lines: host drives when enabled, else the device
  assign dq_bus = fl_dq_oe ? fl_dq_out : fm_dq;
  fcsm_host #(.RP_CYC(2), .READY_CYC(4)) dut (
    .clk, .rst_n, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_data,
    .byte_mode, .rsp_valid, .rsp_data, .rsp_fail, .rsp_refused,
    .sec_lock_mark, .sec_mode, .sec_locked, .vcc_ok, .fl_addr,
    .fl_dq_in(dq_bus), .fl_dq_out, .fl_dq_oe, .chip_select_n, .fl_we_n,
    .fl_oe_n, .fl_reset_n, .ready_busy_n);
  fcsm_flash_model fm (.fl_addr, .dq_bus, .chip_select_n, .fl_we_n,
    .fl_oe_n, .fl_reset_n, .byte_mode, .vcc_ok, .sec_lock_mark,
    .dq_drv(fm_dq), .ready_busy_n);
  initial forever #5 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  // Programming only clears bits of what is stored
  function automatic logic [15:0] exp_prog(input logic [22:0] a,
                                           input logic [15:0] d);
    return (shadow.exists(a) ? shadow[a] : 16'hFFFF) & d;
  endfunction : exp_prog
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic chk16(input logic [15:0] got, exp, input string m);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s: got %h, expected %h", $time, m, got, exp);
    end
  endtask : chk16
  task automatic chk1(input logic got, exp, input string m);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s: got %b, expected %b", $time, m, got, exp);
    end
  endtask : chk1
  // Bounded wait for cmd_ready or for the answer pulse
  task automatic wait_on(input bit rsp, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        err_total++;
        $display("[FAIL] %0t wait ran out", $time);
        end_of_test();
      end
    end while ((rsp ? rsp_valid : cmd_ready) !== 1'h1);
  endtask : wait_on
  // One command: offer, hold until taken, wait for the answer, or for ready again after a pin reset
  task automatic run(input fcsm_op_type op, input logic [22:0] a,
                     input logic [15:0] d);
    @(posedge clk);
    cmd_valid <= 1'h1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    wait_on(1'b0, 3000);
    @(posedge clk);
    cmd_valid <= 1'h0;
    wait_on(op != FCSM_OP_HW_RESET, 20000);
  endtask : run

  initial begin
    logic [22:0] a;
    logic [15:0] d, e;
    int n;
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    // Random programs, slow and prompt device, F0 as data last
    for (int i = 0; i < 6; i++) begin
      rnd = xs(rnd);
      a = rnd[22:0];
      rnd = xs(rnd);
      d = (i == 5) ? 16'h00F0 : rnd[15:0];
      @(posedge clk);
      byte_mode <= rnd[31];
      fm.busy_ns = i[0] ? 300 : 4000;
      e = exp_prog(a, d);
      n = fm.n_ops;
      run(FCSM_OP_PROGRAM, a, d);
      chk16(16'(fm.n_ops - n), 16'h0001, "program start");
      shadow[a] = e;
      run(FCSM_OP_READ, a, 16'h0000);
      chk16(rsp_data, e, "read back");
    end
    // Chip then sector erase
    for (int k = 0; k < 2; k++) begin
      n = fm.n_ops;
      run(k ? FCSM_OP_SECTOR_ERASE : FCSM_OP_CHIP_ERASE, a, 16'h0000);
      chk16(16'(fm.n_ops - n), 16'h0001, "erase start");
      run(FCSM_OP_READ, a, 16'h0000);
      chk16(rsp_data, 16'hFFFF, "erased read");
    end
    shadow.delete();
    @(posedge clk);
    byte_mode <= 1'h0;
    // Identification reads, left by the reset command
    for (int k = 0; k < 2; k++) begin
      run(FCSM_OP_AUTOSEL, k ? 23'h000003 : 23'h000000, 16'h0000);
      chk16(rsp_data, k ? 16'h0000 : 16'h005A, "ident");
      run(FCSM_OP_RESET, a, 16'h0000);
      chk1(fm.id_mode, 1'h0, "ident left");
    end
    run(FCSM_OP_QUERY, 23'h000000, 16'h0000);
    chk1(fm.query, 1'h1, "query entered");
    run(FCSM_OP_READ, a, 16'h0000);
    chk1(fm.query, 1'h0, "query left");
    chk16(rsp_data, 16'hFFFF, "array after query");
    // Failed program is flagged and cleared by the reset write
    fm.fail_next = 1'h1;
    run(FCSM_OP_PROGRAM, a, 16'h1234);
    chk1(rsp_fail, 1'h1, "fail flag");
    chk1(fm.failed, 1'h0, "fail cleared");
    // Lock the region, then erase is refused
    run(FCSM_OP_SEC_ENTER, 23'h000000, 16'h0000);
    chk1(sec_mode, 1'h1, "region entered");
    @(posedge clk);
    sec_lock_mark <= 1'h1;
    @(posedge clk);
    sec_lock_mark <= 1'h0;
    n = fm.n_ops;
    run(FCSM_OP_SECTOR_ERASE, a, 16'h0000);
    chk1(rsp_refused, 1'h1, "locked refusal");
    chk16(16'(fm.n_ops - n), 16'h0000, "no start");
    run(FCSM_OP_SEC_EXIT, a, 16'h0000);
    chk1(fm.sec, 1'h0, "region left");
    run(FCSM_OP_HW_RESET, a, 16'h0000);
    chk1(sec_locked, 1'h1, "lock kept");
    // Supply loss blocks commands; array intact afterwards
    @(posedge clk);
    vcc_ok <= 1'h0;
    repeat (3) @(negedge clk);
    chk1(cmd_ready, 1'h0, "low supply");
    @(posedge clk);
    vcc_ok <= 1'h1;
    run(FCSM_OP_READ, a, 16'h0000);
    chk16(rsp_data, exp_prog(a, 16'h1234), "read after supply");
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
